// >>> dv/bus_master.sv
// Bus master model: start, stop and byte transfers at 11 clocks a bit.
// Assumes the bench resolves the open-drain data wire.
`timescale 1ns/1ns
`default_nettype none
module bus_master
(
  // Clock and resolved data wire
  input wire logic clk,
  input wire logic sda_w,
  // Master pins
  output logic scl,
  output logic sda_m
);
  // Idle bus at time zero
  initial
  begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  task automatic hold;
    repeat (5) @(negedge clk);
  endtask
  task automatic start;
    sda_m = 1'b1;
    hold;
    scl = 1'b1;
    hold;
    sda_m = 1'b0;
    hold;
    scl = 1'b0;
  endtask
  task automatic stop;
    @(negedge clk);
    sda_m = 1'b0;
    hold;
    scl = 1'b1;
    hold;
    sda_m = 1'b1;
    hold;
  endtask
  // Data moves one clock after scl falls, so hold is never zero
  task automatic bit_io(input logic b, output logic r);
    @(negedge clk);
    sda_m = b;
    hold;
    scl = 1'b1;
    hold;
    r = sda_w;
    scl = 1'b0;
  endtask
  // am high releases sda in the acknowledge slot; low acknowledges
  task automatic xfer(input logic [7:0] d, input logic am, output logic [7:0] q, output logic as);
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], q[i]);
    bit_io(am, as);
  endtask
endmodule // bus_master
`default_nettype wire

// >>> dv/port_asserts.sv
// Checker for the register port: strobes, acknowledge timing, stepping.
// Assumes synchronous bus pins and one clock.
`timescale 1ns/1ns
`default_nettype none
module port_asserts
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_oe_b,
  // Register side
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic bus_busy
);
  logic [7:0] lw, lr;
  logic vw, vr;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  function automatic logic [7:0] stp(input logic [7:0] p, input logic r);
    if (p == 8'h46)
      return r ? 8'h4a : 8'h52;
    return (p == 8'h5e) ? 8'h40 : p + 8'h01;
  endfunction
  // Last strobed address, forgotten when idle so a new pointer is free
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      vw <= 1'b0;
      vr <= 1'b0;
    end
    else
    begin
      vw <= bus_busy & (vw | reg_wr);
      vr <= bus_busy & (vr | reg_rd);
      if (reg_wr)
        lw <= reg_addr;
      if (reg_rd)
        lr <= reg_addr;
    end
  end
  wr_pulse_a: assert property (reg_wr |=> !reg_wr) else $error("long strobe");
  idle_release_a: assert property (!bus_busy |-> sda_oe_b) else $error("idle drive");
  start_busy_a: assert property (scl_in && $fell(sda_in) |-> ##[1:3] bus_busy) else $error("no busy");
  stop_idle_a: assert property (scl_in && $rose(sda_in) |-> ##[1:3] !bus_busy) else $error("no idle");
  sda_still_a: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe_b)) else $error("sda moved");
  wr_ack_a: assert property (reg_wr |-> ##[0:4] !sda_oe_b) else $error("no ack");
  wr_step_a: assert property (reg_wr && vw |-> reg_addr == stp(lw, 1'b0)) else $error("wr step");
  rd_step_a: assert property (reg_rd && vr |-> reg_addr == stp(lr, 1'b1)) else $error("rd step");
endmodule // port_asserts
bind i2c_sensor_register_port port_asserts port_asserts_i (.clk(clk), .rst_b(rst_b), .scl_in(scl_in),
  .sda_in(sda_in), .sda_oe_b(sda_oe_b), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .bus_busy(bus_busy));
`default_nettype wire

// >>> dv/testbench.sv
// Bench for the register port: bursts across the gap and the wrap.
// Assumes the master model owns scl and its share of sda.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic scl, sda_m, sda_w, sda_out, sda_oe_b, reg_wr, reg_rd, bus_busy;
  logic [7:0] reg_addr, reg_wdata;
  logic [7:0] regs [0:255];
  logic [7:0] shadow [0:255];
  int mismatches = 0;
  int n_compared = 0;
  int nwr = 0;
  always #4 clk = ~clk;
  // Open drain: either party pulling low wins
  assign sda_w = sda_m & (sda_oe_b | sda_out);
  // Register store; nwr counts write strobes
  always @(posedge clk)
    if (reg_wr)
    begin
      regs[reg_addr] <= reg_wdata;
      nwr <= nwr + 1;
    end
  i2c_sensor_register_port i2c_sensor_register_port_i (.clk(clk), .rst_b(rst_b), .scl_in(scl), .sda_in(sda_w),
    .sda_out(sda_out), .sda_oe_b(sda_oe_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(regs[reg_addr]), .bus_busy(bus_busy));
  bus_master bus_master_i (.clk(clk), .sda_w(sda_w), .scl(scl), .sda_m(sda_m));
  function automatic logic [7:0] nxt(input logic [7:0] p, input logic r);
    if (p == 8'h46)
      return r ? 8'h4a : 8'h52;
    return (p == 8'h5e) ? 8'h40 : p + 8'h01;
  endfunction
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] d);
    logic [7:0] q;
    logic a;
    bus_master_i.xfer(d, 1'b1, q, a);
    cmp({7'h0, a}, 8'h00);
  endtask
  task automatic rd(input logic [7:0] e, input logic last);
    logic [7:0] q;
    logic a;
    bus_master_i.xfer(8'hff, last, q, a);
    cmp(q, e);
  endtask
  // Three writes, then three reads after a repeated start
  task automatic burst(input logic [7:0] p);
    logic [7:0] a;
    bus_master_i.start();
    wr(8'h70);
    wr(p);
    a = p;
    repeat (3)
    begin
      wr(~a);
      shadow[a] = ~a;
      a = nxt(a, 1'b0);
    end
    bus_master_i.stop();
    a = p;
    repeat (3)
    begin
      cmp(regs[a], shadow[a]);
      a = nxt(a, 1'b0);
    end
    bus_master_i.start();
    wr(8'h70);
    wr(p);
    bus_master_i.start();
    wr(8'h71);
    a = p;
    for (int i = 0; i < 3; i++)
    begin
      rd(shadow[a], i == 2);
      a = nxt(a, 1'b1);
    end
    bus_master_i.stop();
  endtask
  // Pointer-only write stores nothing; a bare read starts there
  task automatic ptr_only(input logic [7:0] p);
    int n = nwr;
    bus_master_i.start();
    wr(8'h70);
    wr(p);
    bus_master_i.stop();
    cmp(8'(nwr - n), 8'h00);
    bus_master_i.start();
    wr(8'h71);
    rd(shadow[p], 1'b1);
    bus_master_i.stop();
  endtask
  task automatic wrong_addr;
    logic [7:0] q;
    logic a;
    bus_master_i.start();
    bus_master_i.xfer(8'h72, 1'b1, q, a);
    bus_master_i.stop();
    cmp({7'h0, a}, 8'h01);
  endtask
  task automatic give_verdict;
    if (mismatches == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Run takes about 2900 clocks; allow over eight times that
  initial
  begin
    #200000;
    mismatches++;
    give_verdict;
  end
  initial
  begin
    for (int i = 0; i < 256; i++)
    begin
      regs[i] = i[7:0] ^ 8'h5a;
      shadow[i] = regs[i];
    end
    repeat (5) @(negedge clk);
    rst_b = 1'b1;
    repeat (2) @(negedge clk);
    burst(8'h45);
    burst(8'h5d);
    ptr_only(8'h4c);
    wrong_addr;
    give_verdict;
  end
endmodule // testbench
`default_nettype wire

// >>> src/i2c_sensor_register_port.v
// I2C slave register port: bus address match, pointer byte, auto-increment
// writes and reads through a non-contiguous register window.
// Assumes scl and sda inputs are already synchronous to clk; register
// storage lives outside and is reached over the wr/rd strobes.
`timescale 1ns/1ns
`default_nettype none
`include "sensor_i2c_map.vh"

module i2c_sensor_register_port
(
  // Clock and reset
  input wire clk,
  input wire rst_b,
  // Bus pins, sda open drain (oe low means driving low)
  input wire scl_in,
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe_b,
  // Register side
  output reg [7:0] reg_addr,
  output reg [7:0] reg_wdata,
  output reg reg_wr,
  output reg reg_rd,
  input wire [7:0] reg_rdata,
  // Status
  output reg bus_busy
);

  localparam ST_IDLE = 3'd0;
  localparam ST_ADDR = 3'd1;
  localparam ST_PTR = 3'd2;
  localparam ST_WDATA = 3'd3;
  localparam ST_RDATA = 3'd4;
  localparam ST_ACK = 3'd5;
  localparam ST_MACK = 3'd6;

  reg scl_d_reg;
  reg sda_d_reg;
  reg [2:0] state_reg;
  reg [2:0] after_reg;
  reg [3:0] bit_cnt_reg;
  reg [7:0] shift_reg;
  reg [7:0] ptr_reg;
  reg rd_mode_reg;
  reg drive_low_reg;
  wire [7:0] ptr_step;

  wire scl_rise = scl_in && !scl_d_reg;
  wire scl_fall = !scl_in && scl_d_reg;
  wire start_seen = scl_in && scl_d_reg && sda_d_reg && !sda_in;
  wire stop_seen = scl_in && scl_d_reg && !sda_d_reg && sda_in;

  // read stepping shares the window function
  reg_window_step reg_window_step_i
  (
    .ptr(ptr_reg),
    .is_read(rd_mode_reg),
    .ptr_next(ptr_step)
  );

  // edge history at 125 MHz covers a 3.4 MHz bus clock
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end
    else
    begin
      scl_d_reg <= scl_in;
      sda_d_reg <= sda_in;
    end
  end

  // Protocol engine; the clock pin is only ever read
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_reg <= ST_IDLE;
      after_reg <= ST_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      ptr_reg <= `PTR_RESET;
      rd_mode_reg <= 1'b0;
      drive_low_reg <= 1'b0;
      reg_addr <= `PTR_RESET;
      reg_wdata <= 8'h00;
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      bus_busy <= 1'b0;
    end
    else
    begin
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      reg_addr <= ptr_reg;
      if (start_seen)
      begin
        // Repeated start keeps the pointer for a following read
        state_reg <= ST_ADDR;
        bit_cnt_reg <= 4'h0;
        drive_low_reg <= 1'b0;
        bus_busy <= 1'b1;
      end
      else if (stop_seen)
      begin
        // stop after pointer only leaves registers untouched
        state_reg <= ST_IDLE;
        drive_low_reg <= 1'b0;
        bus_busy <= 1'b0;
      end
      else if (scl_rise && state_reg != ST_IDLE && state_reg != ST_ACK && state_reg != ST_RDATA
               && state_reg != ST_MACK)
      begin
        shift_reg <= {shift_reg[6:0], sda_in};
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
      end
      else if (scl_rise && state_reg == ST_RDATA)
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
      else if (scl_rise && state_reg == ST_MACK)
      begin
        // missing acknowledge ends our driving of sda
        if (sda_in)
          state_reg <= ST_IDLE;
        else
        begin
          // step now so the fetch on the next fall sees the new register
          ptr_reg <= ptr_step;
          bit_cnt_reg <= 4'h0;
        end
      end
      else if (scl_fall)
      begin
        if (state_reg == ST_ACK)
        begin
          drive_low_reg <= 1'b0;
          state_reg <= after_reg;
          bit_cnt_reg <= 4'h0;
          if (after_reg == ST_RDATA)
          begin
            // read begins at the held pointer
            reg_rd <= 1'b1;
            shift_reg <= reg_rdata;
            drive_low_reg <= !reg_rdata[7];
          end
        end
        else if (state_reg == ST_RDATA)
        begin
          if (bit_cnt_reg == 4'h8)
          begin
            drive_low_reg <= 1'b0;
            state_reg <= ST_MACK;
          end
          else
          begin
            shift_reg <= {shift_reg[6:0], 1'b0};
            drive_low_reg <= !shift_reg[6];
          end
        end
        else if (state_reg == ST_MACK && bit_cnt_reg == 4'h0)
        begin
          // Acknowledged: fetch the next byte and drive its top bit
          state_reg <= ST_RDATA;
          reg_rd <= 1'b1;
          shift_reg <= reg_rdata;
          drive_low_reg <= !reg_rdata[7];
        end
        else if (bit_cnt_reg == 4'h8)
        begin
          if (state_reg == ST_ADDR)
          begin
            // only our bus address gets an acknowledge
            if (shift_reg[7:1] == `BUS_ADDR)
            begin
              drive_low_reg <= 1'b1;
              rd_mode_reg <= shift_reg[0];
              after_reg <= shift_reg[0] ? ST_RDATA : ST_PTR;
              state_reg <= ST_ACK;
            end
            else
              state_reg <= ST_IDLE;
          end
          else if (state_reg == ST_PTR)
          begin
            // pointer loads from the low five bits of the byte
            ptr_reg <= {`PTR_PREFIX, shift_reg[4:0]};
            drive_low_reg <= 1'b1;
            after_reg <= ST_WDATA;
            state_reg <= ST_ACK;
          end
          else if (state_reg == ST_WDATA)
          begin
            // store at pointer, then step the write window
            reg_wr <= 1'b1;
            reg_addr <= ptr_reg;
            reg_wdata <= shift_reg;
            ptr_reg <= ptr_step;
            drive_low_reg <= 1'b1;
            after_reg <= ST_WDATA;
            state_reg <= ST_ACK;
          end
        end
      end
    end
  end

  // Open-drain data pin, registered so the pad comes from a flip-flop
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sda_out <= 1'b1;
      sda_oe_b <= 1'b1;
    end
    else
    begin
      sda_out <= 1'b0;
      sda_oe_b <= !drive_low_reg;
    end
  end

endmodule // i2c_sensor_register_port
`default_nettype wire

// >>> src/reg_window_step.v
// Next-register function for the non-contiguous register window.
// Purely combinational; caller supplies the current pointer.
`timescale 1ns/1ns
`default_nettype none
`include "sensor_i2c_map.vh"

module reg_window_step
(
  // Current pointer and direction
  input wire [7:0] ptr,
  input wire is_read,
  // Following register
  output reg [7:0] ptr_next
);

  // Gap handling differs between read and write
  always @*
  begin
    if (ptr >= `REG_LAST || ptr < `REG_FIRST)
      ptr_next = `REG_FIRST;
    else if (ptr == `WR_GAP_LAST)
      ptr_next = is_read ? `RD_JUMP : `WR_JUMP;
    else if (!is_read && ptr > `WR_GAP_LAST && ptr < `WR_JUMP)
      ptr_next = `WR_JUMP;
    else if (is_read && ptr > `WR_GAP_LAST && ptr < `RD_JUMP)
      ptr_next = `RD_JUMP;
    else
      ptr_next = ptr + 8'h01;
  end

endmodule // reg_window_step
`default_nettype wire

// >>> src/sensor_i2c_map.vh
// Constants for the sensor register port: bus address, pointer layout,
// register window bounds and bus timing figures.
// Assumes a 125 MHz system clock sampling the bus pins.
`ifndef SENSOR_I2C_MAP_VH
`define SENSOR_I2C_MAP_VH

`define BUS_ADDR 7'h38
`define PTR_PREFIX 3'h2
`define REG_FIRST 8'h40
`define WR_GAP_LAST 8'h46
`define WR_JUMP 8'h52
`define RD_JUMP 8'h4a
`define REG_LAST 8'h5e
`define PTR_RESET 8'h40
`define CLK_NS 8
// Hs data valid after SCL low, at most 70 ns hold is respected by 8 cycles
`define HS_HOLD_NS 70
`define HOLD_CYC (((`HS_HOLD_NS) / (`CLK_NS)) > 0 ? ((`HS_HOLD_NS) / (`CLK_NS)) : 1)

`endif
